// *** rtl/nfa_annunciator.sv ***
// nfa_annunciator: catches non-fatal controller errors, queues their
// fault codes, flashes the alarm indicator and keeps diagnostic words.
// assumes event inputs are synchronous one-cycle pulses or levels and an
// apb master on the register side.
`timescale 1ns/1ns
module nfa_annunciator
    import nfa_pkg::*;
#(
    parameter int ISR_CYC = ISR_LIMIT_CYC,
    parameter int WDT_CYC = WDT_LIMIT_CYC,
    parameter int BLINK_CYC = BLINK_HALF_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller state
    input wire logic program_mode,
    input wire logic scan_end,
    // user alarm instruction
    input wire logic user_alarm_exec,
    input wire logic [7:0] user_alarm_num,
    // interrupt input and interrupt routine
    input wire logic intr_unit_xfer_err,
    input wire logic isr_active,
    input wire logic remote_refresh_busy,
    input wire logic host_link_busy,
    // special unit refresh requests
    input wire logic refresh_req,
    input wire logic [1:0] refresh_req_type,
    // high-density units
    input wire logic hd_xfer_err,
    input wire logic [3:0] hd_unit,
    // controller setup table
    input wire logic setup_read,
    input wire logic [SETUP_W-1:0] setup_bad,
    // communications board
    input wire logic comm_board_err,
    // memory cassette transfer
    input wire logic cassette_xfer_req,
    input wire logic um_read_only,
    input wire logic cassette_read_only,
    input wire logic capacity_ok,
    input wire logic cassette_csum_bad,
    // io table, remote io, units, battery
    input wire logic io_table_mismatch,
    input wire logic remote_err,
    input wire logic remote_master,
    input wire logic unit_err,
    input wire logic [3:0] unit_err_num,
    input wire logic battery_low,
    // indicators and status
    output logic power_led,
    output logic run_led,
    output logic alarm_error_indicator,
    output logic cpu_run_enable,
    output logic cassette_xfer_go,
    output logic [7:0] fault_code,
    output logic [RESTART_W-1:0] restart_bits
);
    nfa_queue_if q ();

    nfa_code_queue u_queue (
        .mclk(mclk),
        .reset(reset),
        .q(q.store)
    );

    nfa_blinker #(.HALF_CYC(BLINK_CYC)) u_blink (
        .mclk(mclk),
        .reset(reset),
        .enable(!q.empty),
        .blink(alarm_error_indicator)
    );

    // index of the lowest pending source
    function automatic int first_set(input logic [NSRC-1:0] v);
        int idx;
        idx = 0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    function automatic logic rose(input logic cur, input logic prev);
        return cur && !prev;
    endfunction

    // user number is two bcd digits, 01..99
    function automatic logic bcd_ok(input logic [7:0] n);
        return n[7:4] <= 4'h9 && n[3:0] <= 4'h9;
    endfunction

    // ---------------- timers and edge history
    logic [TMR_W-1:0] wdt_reg, wdt_next, isr_reg, isr_next;
    logic isr_hit_reg, isr_hit_next;
    logic iot_prev_reg, iot_prev_next, bat_prev_reg, bat_prev_next;
    logic ev_cycle, ev_isr, isr_slow;

    always_comb begin
        isr_slow = isr_active && (remote_refresh_busy || host_link_busy);
        wdt_next = wdt_reg;
        ev_cycle = 1'b0;
        if (scan_end) begin
            wdt_next = '0;
        end else if (wdt_reg <= TMR_W'(WDT_CYC)) begin
            wdt_next = wdt_reg + 1'b1;
        end
        if (!scan_end && wdt_reg == TMR_W'(WDT_CYC)) begin
            ev_cycle = 1'b1;
        end
        isr_next = isr_slow ? isr_reg + 1'b1 : '0;
        isr_hit_next = isr_hit_reg && isr_active;
        ev_isr = 1'b0;
        if (isr_slow && !isr_hit_reg && isr_reg >= TMR_W'(ISR_CYC)) begin
            ev_isr = 1'b1;
            isr_hit_next = 1'b1;
        end
        if (isr_hit_next || !isr_slow) begin
            isr_next = '0;
        end
        iot_prev_next = io_table_mismatch;
        bat_prev_next = battery_low;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wdt_reg <= '0;
            isr_reg <= '0;
            isr_hit_reg <= 1'b0;
            iot_prev_reg <= 1'b0;
            bat_prev_reg <= 1'b0;
        end else begin
            wdt_reg <= wdt_next;
            isr_reg <= isr_next;
            isr_hit_reg <= isr_hit_next;
            iot_prev_reg <= iot_prev_next;
            bat_prev_reg <= bat_prev_next;
        end
    end

    // ---------------- apb decode
    logic acc, wr_acc, rd_setup, mapped;
    logic [1:0] ctrl_reg, ctrl_next;
    logic [RESTART_W-1:0] rst_reg, rst_next;
    logic [31:0] rdata_reg, rdata_next;
    logic clr_pop, clr_status;

    // ---------------- events into pending sources
    logic [NSRC-1:0] pend_reg, pend_next, ev;
    nfa_code_t user_reg, user_next;
    logic remote_sel_reg, remote_sel_next;
    logic [HD_UNITS-1:0] hd_reg, hd_next;
    logic [SETUP_W-1:0] setup_reg, setup_next;
    logic setup_seen_reg, setup_seen_next;
    logic [3:0] unit_reg, unit_next;
    logic unit_v_reg, unit_v_next;
    logic go_reg, go_next;
    nfa_code_t sel_code;
    logic cass_bad, user_set;
    int pick;

    always_comb begin
        ev = '0;
        user_set = user_alarm_exec && user_alarm_num != FC_NONE &&
                   bcd_ok(user_alarm_num) &&
                   user_alarm_num <= FC_USER_MAX;
        ev[SRC_USER] = user_set;
        ev[SRC_INTR] = intr_unit_xfer_err;
        ev[SRC_ISR] = ev_isr;
        ev[SRC_REFR] = refresh_req && refresh_req_type != ctrl_reg;
        ev[SRC_HD] = hd_xfer_err;
        ev[SRC_SETUP] = setup_read && !setup_seen_reg && |setup_bad;
        ev[SRC_COMM] = comm_board_err;
        cass_bad = !program_mode || um_read_only || cassette_read_only ||
                   !capacity_ok || cassette_csum_bad;
        ev[SRC_CASS] = cassette_xfer_req && cass_bad;
        ev[SRC_CYCLE] = ev_cycle;
        ev[SRC_IOTBL] = rose(io_table_mismatch, iot_prev_reg);
        ev[SRC_REMOTE] = remote_err;
        ev[SRC_BATT] = rose(battery_low, bat_prev_reg);

        // queue one pending source per cycle; held back while full
        pick = first_set(pend_reg);
        user_next = user_set ? user_alarm_num : user_reg;
        remote_sel_next = remote_err ? remote_master : remote_sel_reg;
        unique case (pick)
            SRC_USER: sel_code = user_reg;
            SRC_INTR: sel_code = FC_INTR_UNIT;
            SRC_ISR, SRC_REFR: sel_code = FC_ISR_REFRESH;
            SRC_HD: sel_code = FC_HD_UNIT;
            SRC_SETUP: sel_code = FC_SETUP;
            SRC_COMM: sel_code = FC_COMM;
            SRC_CASS: sel_code = FC_CASSETTE;
            SRC_CYCLE: sel_code = FC_CYCLE;
            SRC_IOTBL: sel_code = FC_IO_TABLE;
            SRC_REMOTE: sel_code = remote_sel_reg ? FC_REMOTE1 : FC_REMOTE0;
            default: sel_code = FC_BATTERY;
        endcase
        q.push = |pend_reg && !q.full;
        q.push_code = sel_code;
        pend_next = pend_reg;
        if (q.push) begin
            pend_next[pick] = 1'b0;
        end
        pend_next = pend_next | ev; // a new event wins over the take

        // user alarm 00 pops in any mode, software clear only in program
        q.pop = (user_alarm_exec && user_alarm_num == FC_NONE) ||
                (clr_pop && program_mode);

        hd_next = hd_reg;
        setup_next = setup_reg;
        unit_next = unit_reg;
        unit_v_next = unit_v_reg;
        if (clr_status && program_mode) begin
            hd_next = '0;
            setup_next = '0;
            unit_v_next = 1'b0;
        end
        if (hd_xfer_err && hd_unit < 4'(HD_UNITS)) begin
            hd_next[hd_unit] = 1'b1;
        end
        setup_seen_next = setup_seen_reg || setup_read;
        if (ev[SRC_SETUP]) begin
            setup_next = setup_next | setup_bad;
        end
        if (unit_err) begin
            unit_next = unit_err_num;
            unit_v_next = 1'b1;
        end
        go_next = cassette_xfer_req && !cass_bad;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pend_reg <= '0;
            user_reg <= FC_NONE;
            remote_sel_reg <= 1'b0;
            hd_reg <= '0;
            setup_reg <= '0;
            setup_seen_reg <= 1'b0;
            unit_reg <= '0;
            unit_v_reg <= 1'b0;
            go_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            user_reg <= user_next;
            remote_sel_reg <= remote_sel_next;
            hd_reg <= hd_next;
            setup_reg <= setup_next;
            setup_seen_reg <= setup_seen_next;
            unit_reg <= unit_next;
            unit_v_reg <= unit_v_next;
            go_reg <= go_next;
        end
    end

    // ---------------- apb registers
    always_comb begin
        acc = psel && penable;
        wr_acc = acc && pwrite;
        rd_setup = psel && !penable && !pwrite;
        unique case (paddr)
            OFF_FAULT, OFF_CLEAR, OFF_HD_FLAGS, OFF_SETUP_ERR,
            OFF_UNIT, OFF_RESTART, OFF_CTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        clr_pop = wr_acc && paddr == OFF_CLEAR && pwdata[CLEAR_POP_BIT];
        clr_status = wr_acc && paddr == OFF_CLEAR &&
                     pwdata[CLEAR_STATUS_BIT];
        ctrl_next = ctrl_reg;
        rst_next = rst_reg;
        if (wr_acc && paddr == OFF_CTRL) begin
            ctrl_next = pwdata[1:0];
        end
        if (wr_acc && paddr == OFF_RESTART) begin
            rst_next = pwdata[RESTART_W-1:0];
        end
        rdata_next = rdata_reg;
        if (rd_setup) begin
            rdata_next = '0;
            unique case (paddr)
                OFF_FAULT: begin
                    rdata_next[7:0] = q.head;
                    rdata_next[FAULT_VALID_BIT] = !q.empty;
                    rdata_next[FAULT_CNT_LSB +: QCNT_W] = q.count;
                end
                OFF_HD_FLAGS: rdata_next[HD_UNITS-1:0] = hd_reg;
                OFF_SETUP_ERR: rdata_next[SETUP_W-1:0] = setup_reg;
                OFF_UNIT: begin
                    rdata_next[3:0] = unit_reg;
                    rdata_next[UNIT_VALID_BIT] = unit_v_reg;
                    rdata_next[UNIT_REMOTE_BIT] = remote_sel_reg;
                end
                OFF_RESTART: rdata_next[RESTART_W-1:0] = rst_reg;
                OFF_CTRL: rdata_next[1:0] = ctrl_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
            rst_reg <= '0;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            rst_reg <= rst_next;
            rdata_reg <= rdata_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign power_led = 1'b1;
    assign run_led = 1'b1;
    assign cpu_run_enable = 1'b1;
    assign cassette_xfer_go = go_reg;
    assign fault_code = q.head;
    assign restart_bits = rst_reg;
endmodule

// *** include/nfa_pkg.sv ***
// nfa_pkg: constants, fault codes, register map and timing of the
// non-fatal error annunciator. assumes a 10 MHz core clock.
package nfa_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int ISR_LIMIT_MS = 10;
    localparam int WDT_LIMIT_MS = 100;
    localparam int BLINK_HALF_MS = 500;
    localparam int ISR_LIMIT_CYC = ISR_LIMIT_MS * (CLK_HZ / 1000);
    localparam int WDT_LIMIT_CYC = WDT_LIMIT_MS * (CLK_HZ / 1000);
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 24;

    typedef logic [7:0] nfa_code_t;

    localparam int QDEPTH = 8;
    localparam int QPTR_W = 3;
    localparam int QCNT_W = 4;

    // two hex digit fault codes
    localparam nfa_code_t FC_NONE = 8'h00;
    localparam nfa_code_t FC_INTR_UNIT = 8'h8a;
    localparam nfa_code_t FC_ISR_REFRESH = 8'h8b;
    localparam nfa_code_t FC_HD_UNIT = 8'h9a;
    localparam nfa_code_t FC_SETUP = 8'h9b;
    localparam nfa_code_t FC_COMM = 8'h9c;
    localparam nfa_code_t FC_CASSETTE = 8'h9d;
    localparam nfa_code_t FC_CYCLE = 8'hf8;
    localparam nfa_code_t FC_IO_TABLE = 8'he7;
    localparam nfa_code_t FC_REMOTE0 = 8'hb0;
    localparam nfa_code_t FC_REMOTE1 = 8'hb1;
    localparam nfa_code_t FC_BATTERY = 8'hf7;
    localparam nfa_code_t FC_USER_MAX = 8'h99;

    // pending sources, lowest index is queued first
    localparam int SRC_USER = 0;
    localparam int SRC_INTR = 1;
    localparam int SRC_ISR = 2;
    localparam int SRC_REFR = 3;
    localparam int SRC_HD = 4;
    localparam int SRC_SETUP = 5;
    localparam int SRC_COMM = 6;
    localparam int SRC_CASS = 7;
    localparam int SRC_CYCLE = 8;
    localparam int SRC_IOTBL = 9;
    localparam int SRC_REMOTE = 10;
    localparam int SRC_BATT = 11;
    localparam int NSRC = 12;

    localparam int HD_UNITS = 10;
    localparam int SETUP_W = 3;
    localparam int RESTART_W = 16;

    // apb register byte offsets
    localparam logic [7:0] OFF_FAULT = 8'h00;
    localparam logic [7:0] OFF_CLEAR = 8'h04;
    localparam logic [7:0] OFF_HD_FLAGS = 8'h08;
    localparam logic [7:0] OFF_SETUP_ERR = 8'h0c;
    localparam logic [7:0] OFF_UNIT = 8'h10;
    localparam logic [7:0] OFF_RESTART = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;

    // field positions
    localparam int FAULT_VALID_BIT = 8;
    localparam int FAULT_CNT_LSB = 12;
    localparam int CLEAR_POP_BIT = 0;
    localparam int CLEAR_STATUS_BIT = 1;
    localparam int UNIT_VALID_BIT = 4;
    localparam int UNIT_REMOTE_BIT = 8;
    localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage

// *** include/nfa_queue_if.sv ***
// nfa_queue_if: push/pop link between the annunciator and its code queue.
// assumes one clock shared by both ends.
`timescale 1ns/1ns
interface nfa_queue_if;
    import nfa_pkg::*;
    logic push;
    nfa_code_t push_code;
    logic pop;
    nfa_code_t head;
    logic empty;
    logic full;
    logic [QCNT_W-1:0] count;
    modport owner (output push, push_code, pop,
                   input head, empty, full, count);
    modport store (input push, push_code, pop,
                   output head, empty, full, count);
endinterface

// *** rtl/nfa_code_queue.sv ***
// nfa_code_queue: first-in first-out store of pending fault codes.
// assumes the owner never pushes while full.
`timescale 1ns/1ns
module nfa_code_queue
    import nfa_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // queue link
    nfa_queue_if.store q
);
    nfa_code_t mem [QDEPTH];
    logic [QPTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [QCNT_W-1:0] cnt_reg, cnt_next;
    logic do_push, do_pop;

    always_comb begin
        do_push = q.push && !q.full;
        do_pop = q.pop && !q.empty;
        wr_next = do_push ? wr_reg + 1'b1 : wr_reg;
        rd_next = do_pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + QCNT_W'(do_push) - QCNT_W'(do_pop);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
        if (do_push) begin
            mem[wr_reg] <= q.push_code;
        end
    end

    assign q.empty = (cnt_reg == '0);
    assign q.full = (cnt_reg == QCNT_W'(QDEPTH));
    assign q.count = cnt_reg;
    assign q.head = q.empty ? FC_NONE : mem[rd_reg];
endmodule

// *** rtl/nfa_blinker.sv ***
// nfa_blinker: square wave for the flashing alarm indicator.
// assumes enable is a level; output is low while disabled.
`timescale 1ns/1ns
module nfa_blinker
    import nfa_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    input wire logic enable,
    output logic blink
);
    logic [TMR_W-1:0] cnt_reg, cnt_next;
    logic ph_reg, ph_next;

    always_comb begin
        cnt_next = cnt_reg + 1'b1;
        ph_next = ph_reg;
        if (!enable) begin
            cnt_next = '0;
            ph_next = 1'b1;
        end else if (cnt_reg >= TMR_W'(HALF_CYC - 1)) begin
            cnt_next = '0;
            ph_next = !ph_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_reg <= '0;
            ph_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ph_reg <= ph_next;
        end
    end

    assign blink = enable && ph_reg;
endmodule

// *** test/nfa_annunciator_assertions.sv ***
// nfa_annunciator_assertions: port-level checks of the annunciator.
// assumes binding to nfa_annunciator, one clock, sync active-high reset.
`timescale 1ns/1ns
module nfa_annunciator_assertions
    import nfa_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // events
    input wire logic program_mode,
    input wire logic user_alarm_exec,
    input wire logic intr_unit_xfer_err,
    input wire logic cassette_xfer_req,
    input wire logic um_read_only,
    input wire logic cassette_read_only,
    input wire logic capacity_ok,
    input wire logic cassette_csum_bad,
    // outputs
    input wire logic power_led,
    input wire logic run_led,
    input wire logic alarm_error_indicator,
    input wire logic cpu_run_enable,
    input wire logic cassette_xfer_go,
    input wire logic [7:0] fault_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [7:0] hi_cnt, lo_cnt, hi_next, lo_next;
    logic cass_ok, clr_run;
    assign cass_ok = program_mode && !um_read_only && !cassette_read_only
        && capacity_ok && !cassette_csum_bad;
    assign clr_run = psel && penable && pwrite && paddr == 8'h04
        && pwdata[0] && !program_mode && fault_code != 8'h00;
    // length of the current lit and dark stretch of the indicator
    always_comb begin
        hi_next = alarm_error_indicator ? hi_cnt + 8'h01 : 8'h00;
        lo_next = (!alarm_error_indicator && fault_code != 8'h00) ?
            lo_cnt + 8'h01 : 8'h00;
    end
    always_ff @(posedge mclk) begin
        hi_cnt <= reset ? 8'h00 : hi_next;
        lo_cnt <= reset ? 8'h00 : lo_next;
    end
    sequence s_no_pop;
        !user_alarm_exec ##1 !user_alarm_exec;
    endsequence
    a_run_kept:
        assert property (cpu_run_enable && power_led && run_led)
        else $error("run or power indication dropped");
    a_dark_empty:
        assert property (fault_code == 8'h00 |-> !alarm_error_indicator)
        else $error("alarm lit with no fault pending");
    a_flash_high:
        assert property (hi_cnt <= BLINK_CYC)
        else $error("alarm lit too long");
    a_flash_low:
        assert property (lo_cnt <= BLINK_CYC)
        else $error("alarm dark too long while pending");
    a_event_shows:
        assert property ((intr_unit_xfer_err && fault_code == 8'h00)
            ##0 s_no_pop |-> ##1 fault_code != 8'h00)
        else $error("fault not shown two cycles after event");
    a_cass_go:
        assert property (cassette_xfer_req && cass_ok |=> cassette_xfer_go)
        else $error("good cassette request not started");
    a_cass_block:
        assert property (cassette_xfer_req && !cass_ok |=> !cassette_xfer_go)
        else $error("bad cassette request started");
    a_clear_run:
        assert property (clr_run && !user_alarm_exec
            && !$past(user_alarm_exec) |=> $stable(fault_code))
        else $error("fault cleared outside program mode");
    a_reset_clear:
        assert property ($fell(reset) |-> fault_code == 8'h00
            && !alarm_error_indicator)
        else $error("fault state not cleared by reset");
endmodule
bind nfa_annunciator nfa_annunciator_assertions #(.BLINK_CYC(BLINK_CYC))
    u_nfa_annunciator_assertions (.mclk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .program_mode, .user_alarm_exec, .intr_unit_xfer_err,
    .cassette_xfer_req, .um_read_only, .cassette_read_only, .capacity_ok,
    .cassette_csum_bad, .power_led, .run_led, .alarm_error_indicator,
    .cpu_run_enable, .cassette_xfer_go, .fault_code);

// *** test/nfa_scan_model.sv ***
// nfa_scan_model: behavioural scan logic giving end-of-scan pulses.
// assumes one clock shared with the annunciator.
`timescale 1ns/1ns
module nfa_scan_model #(
    parameter int PERIOD = 10
)(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control from bench
    input wire logic stall,
    // to annunciator
    output logic scan_end
);
    int cnt;
    // a stalled scan never ends, so the watchdog counts past its limit and then holds
    always_ff @(posedge mclk) begin
        if (reset || stall) begin
            cnt <= 0;
            scan_end <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            scan_end <= (cnt == PERIOD - 1);
        end
    end
endmodule

// *** test/nfa_annunciator_tb.sv ***
// nfa_annunciator_tb: self-checking bench of the annunciator.
// assumes short timer parameters and a scan model partner.
`timescale 1ns/1ns
module nfa_annunciator_tb;
    import nfa_pkg::*;
    localparam int ISR = 20;
    localparam int WDT = 50;
    logic mclk, reset, psel, penable, pwrite, program_mode, pready, pslverr;
    logic [7:0] paddr, unum, ev;
    logic [31:0] pwdata, prdata, rd, wv;
    logic pled, rled, alarm, run_en, go, se, er, rmst, stall;
    logic um_ro, c_ro, cap_ok, csum, iot, batt, isr, hbusy;
    logic [1:0] rtype;
    logic [3:0] hdu;
    logic [2:0] sbad;
    logic [15:0] rbits;
    nfa_code_t fcode, e;
    integer seed, num_errors, checked, cyc, t;
    nfa_annunciator #(.ISR_CYC(ISR), .WDT_CYC(WDT), .BLINK_CYC(4))
        u_nfa_annunciator (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .program_mode(program_mode), .scan_end(se),
        .user_alarm_exec(ev[0]), .user_alarm_num(unum),
        .intr_unit_xfer_err(ev[1]), .isr_active(isr),
        .remote_refresh_busy(rmst), .host_link_busy(hbusy),
        .refresh_req(ev[2]), .refresh_req_type(rtype), .hd_xfer_err(ev[3]),
        .hd_unit(hdu), .setup_read(ev[4]), .setup_bad(sbad),
        .comm_board_err(ev[5]), .cassette_xfer_req(ev[6]),
        .um_read_only(um_ro), .cassette_read_only(c_ro),
        .capacity_ok(cap_ok), .cassette_csum_bad(csum),
        .io_table_mismatch(iot), .remote_err(ev[7]), .remote_master(rmst),
        .unit_err(ev[7]), .unit_err_num(hdu), .battery_low(batt),
        .power_led(pled), .run_led(rled), .alarm_error_indicator(alarm),
        .cpu_run_enable(run_en), .cassette_xfer_go(go), .fault_code(fcode),
        .restart_bits(rbits));
    nfa_scan_model #(.PERIOD(10)) u_nfa_scan_model (.mclk(mclk),
        .reset(reset), .stall(stall), .scan_end(se));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pulse(input logic [7:0] bits);
        @(posedge mclk);
        ev <= bits;
        @(posedge mclk);
        ev <= 8'h00;
        repeat (3) @(posedge mclk);
    endtask
    function automatic nfa_code_t exp_code(input int k, input logic [7:0] n,
        input logic m);
        case (k)
            0: return n;
            1: return FC_INTR_UNIT;
            2, 9: return FC_ISR_REFRESH;
            3: return FC_HD_UNIT;
            4: return FC_SETUP;
            5: return FC_COMM;
            6: return FC_CASSETTE;
            7: return m ? FC_REMOTE1 : FC_REMOTE0;
            8: return FC_IO_TABLE;
            10: return FC_BATTERY;
            default: return FC_CYCLE;
        endcase
    endfunction
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors = num_errors + 1;
            $display("[ERR] run expected done seen hung");
            finish_test();
        end
    end
    initial begin
        {seed, num_errors, checked, cyc} = {32'h7caa, 96'h0};
        {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
        {program_mode, unum, ev, rtype, hdu, sbad, rmst, stall} = 28'h0;
        {um_ro, c_ro, cap_ok, csum, iot, batt, isr, hbusy} = 8'h20;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {er, rd[30:0]}, 32'h80000000);
        wv = $random(seed);
        apb(1'b1, OFF_RESTART, wv);
        apb(1'b0, OFF_RESTART, 32'h0);
        check("restart", {rbits, rd[15:0]}, {2{wv[15:0]}});
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 12; k++) begin
                t = $unsigned($random(seed)) % 99 + 1;
                unum <= {4'(t / 10), 4'(t % 10)};
                rtype <= 2'($unsigned($random(seed)) % 3 + 1);
                hdu <= 4'($unsigned($random(seed)) % 10);
                sbad <= 3'($unsigned($random(seed)) % 7 + 1);
                rmst <= 1'($random(seed));
                program_mode <= 1'(r);
                csum <= 1'(r);
                @(posedge mclk);
                case (k)
                    8: iot <= 1'b1;
                    9: {isr, hbusy} <= {1'b1, !rmst};
                    10: batt <= 1'b1;
                    11: stall <= 1'b1;
                    default: ev[k] <= 1'b1;
                endcase
                repeat (k == 9 ? ISR + 3 : (k == 11 ? WDT + 5 : 1))
                    @(posedge mclk);
                {ev, isr, stall} <= 10'h0;
                repeat (3) @(posedge mclk);
                e = (k == 4 && r == 1) ? FC_NONE : exp_code(k, unum, rmst);
                check("fault_code", fcode, e);
                apb(1'b0, OFF_FAULT, 32'h0);
                check("fault_reg", rd[8:0], {e != FC_NONE, e});
                if (k == 3) begin
                    apb(1'b0, OFF_HD_FLAGS, 32'h0);
                    check("hd_flag", rd[hdu], 1'b1);
                end
                if (k == 4 && r == 0) begin
                    apb(1'b0, OFF_SETUP_ERR, 32'h0);
                    check("setup_err", rd[2:0], sbad);
                end
                if (k == 7) begin
                    apb(1'b0, OFF_UNIT, 32'h0);
                    check("unit", rd[8:0], {rmst, 4'h1, hdu});
                end
                {iot, batt, hbusy} <= 3'h0;
                unum <= 8'h00;
                pulse(8'h01);
                check("pop", {alarm, fcode}, 9'h0);
            end
        end
        program_mode <= 1'b0;
        unum <= 8'h42;
        pulse(8'h23);
        check("queue_head", fcode, 8'h42);
        apb(1'b1, OFF_CLEAR, 32'h1);
        check("run_clear", fcode, 8'h42);
        program_mode <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_CLEAR, 32'h3);
            apb(1'b0, OFF_HD_FLAGS, 32'h0);
            check("status_clear", rd[9:0], 10'h0);
            check("queue_next", fcode, i == 0 ? FC_INTR_UNIT :
                (i == 1 ? FC_COMM : FC_NONE));
        end
        csum <= 1'b0;
        pulse(8'h40);
        check("cassette_ok", {alarm, fcode}, 9'h0);
        finish_test();
    end
endmodule
